// ### core/sst_start_stop_select.sv
// command source selector and decoder for start, stop and rotation direction
//
// Behaviour
// (R1) source none: no start, stop or direction is taken from anything.
// (R2) two-wire on input one: low stops, high runs, direction from lock.
// (R3) two-wire with direction: input one runs, input two low forward high reverse.
// (R4) pulse scheme: high on input one starts, low on input two stops.
// (R5) pulse with direction: as pulse scheme, input three gives direction.
// (R6) three-pulse: input one starts forward, two starts reverse, three low stops.
// (R7) two-wire on input six: low stops, high runs, direction from lock.
// (R8) two-wire six with direction: input five low forward, high reverse.
// (R9) keypad source: keypad start, stop, direction while location one active; the code also takes them at location two if src_two is SRC_KEYPAD.
// (R10) communication module source: commands come from the module only.
// (R11) direction lock forward, reverse or follow; requests honoured only when following.
// (R12) source and lock settings change only while the motor is stopped.
// (R13) location select picks location one or two; only its source applies.
// (R14) level schemes run again right after fault reset if input still high.
// (R15) two user sets: save all settings and motor data, slow; load restores.
// (R16) user set also holds panel reference and local or remote state.
// (R17) load also restores motor start-up settings and identification results.
// (R18) a digital input may switch between the two user sets.
// (R19) an input keeps every function assigned to it, none is cleared.
// (R20) pulse schemes latch run on start until stop opens; stop overrides.
`default_nettype none

module sst_start_stop_select
	import sst_pkg::*;
#(
	parameter longint unsigned SAVE_CYCLES_P = SAVE_CYCLES
) (
	input  wire logic                      clock_i,
	input  wire logic                      resetn_i,
	input  wire logic                      enable_i,
	input  wire logic [DIN_COUNT-1:0]      din_i,
	input  wire logic                      running_i,
	input  wire logic                      fault_trip_i,
	input  wire logic                      fault_reset_i,
	input  wire logic                      keypad_start_i,
	input  wire logic                      keypad_stop_i,
	input  wire logic                      keypad_reverse_i,
	input  wire logic                      comm_run_i,
	input  wire logic                      comm_reverse_i,
	input  wire logic                      comm_loc_two_i,
	input  wire logic                      cfg_write_i,
	input  wire sst_cfg_s                  cfg_wdata_i,
	input  wire logic                      uset_save_i,
	input  wire logic                      uset_load_i,
	input  wire logic                      uset_sel_i,
	input  wire logic                      uset_input_en_i,
	input  wire logic [DIN_IDX_W-1:0]      uset_input_idx_i,
	input  wire logic [PANEL_REF_W-1:0]    panel_ref_i,
	input  wire logic                      remote_i,
	input  wire logic [MOTOR_SETUP_W-1:0]  motor_setup_i,
	input  wire logic [MOTOR_ID_W-1:0]     motor_id_i,
	output logic                           run_o,
	output logic                           reverse_o,
	output logic                           loc_two_o,
	output logic                           faulted_o,
	output sst_cfg_s                       cfg_o,
	output logic                           cfg_reject_o,
	output logic                           uset_busy_o,
	output logic                           restore_valid_o,
	output sst_uset_s                      restore_o
);

	typedef struct packed {
		sst_cfg_s   cfg;
		logic       loc_two;
		logic       latch;
		logic       latch_rev;
		logic       faulted;
		logic       run;
		logic       reverse;
		logic       cfg_reject;
		logic       uset_busy;
		logic       uset_level;
		logic       restore_valid;
		sst_uset_s  restore;
	} sst_top_state_s;

	localparam sst_top_state_s TOP_RESET = '{cfg: CFG_RESET, default: '0};

	sst_top_state_s        st_ff;
	sst_top_state_s        nxt_st;
	logic [DIN_COUNT-1:0]  din_s;
	logic                  uset_busy;
	logic                  uset_done;
	sst_uset_s             uset_data;
	sst_uset_s             snap;
	sst_src_e              src_now;
	logic                  loc_two_now;
	logic                  fault_now;
	logic                  req_run;
	logic                  req_rev;
	logic                  latch;
	logic                  latch_rev;
	logic                  sel_level;
	logic                  din_edge;
	logic                  load_want;
	logic                  uset_load_req;
	logic                  uset_sel_req;

	sst_sync #(
		.WIDTH    (DIN_COUNT)
	) u_sync (
		.clock_i  (clock_i),
		.resetn_i (resetn_i),
		.enable_i (enable_i),
		.async_i  (din_i),
		.sync_o   (din_s)
	);

	assign snap = '{
		cfg:         st_ff.cfg,
		panel_ref:   panel_ref_i,
		remote:      remote_i,
		motor_setup: motor_setup_i,
		motor_id:    motor_id_i
	};

	sst_user_set #(
		.SAVE_CYCLES_P (SAVE_CYCLES_P)
	) u_user_set (
		.clock_i  (clock_i),
		.resetn_i (resetn_i),
		.enable_i (enable_i),
		.save_i   (uset_save_i),
		.load_i   (uset_load_req),
		.sel_i    (uset_sel_req),
		.snap_i   (snap),
		.busy_o   (uset_busy),
		.done_o   (uset_done),
		.data_o   (uset_data)
	);

	always_comb begin
		nxt_st               = st_ff;
		nxt_st.cfg_reject    = 1'b0;
		nxt_st.restore_valid = 1'b0;
		nxt_st.uset_busy     = uset_busy;
		loc_two_now          = 1'b0;
		req_run              = 1'b0;
		req_rev              = 1'b0;
		latch                = st_ff.latch;
		latch_rev            = st_ff.latch_rev;

		// a trip in the same cycle as a reset keeps the fault
		fault_now      = (st_ff.faulted && !fault_reset_i) || fault_trip_i;
		nxt_st.faulted = fault_now;

		// the selecting input may also be a command input of either location
		unique case (st_ff.cfg.loc_sel)
			LOC_ONE:   loc_two_now = 1'b0; // see R13
			LOC_TWO:   loc_two_now = 1'b1; // see R13
			LOC_INPUT: begin // see R13, R19
				loc_two_now = (st_ff.cfg.loc_input_idx < DIN_IDX_W'(DIN_COUNT)) ?
					din_s[st_ff.cfg.loc_input_idx] : 1'b0;
			end
			LOC_COMM:  loc_two_now = comm_loc_two_i; // see R13
		endcase
		src_now = loc_two_now ? st_ff.cfg.src_two : st_ff.cfg.src_one; // see R13
		// a held start must not carry across a location change
		if (loc_two_now != st_ff.loc_two) begin
			latch     = 1'b0;
			latch_rev = 1'b0;
		end

		unique case (src_now)
			SRC_NONE: begin
				req_run = 1'b0; // see R1
			end
			SRC_TWO_WIRE_ONE: begin
				req_run = din_s[DIN_ONE]; // see R2
			end
			SRC_TWO_WIRE_WITH_DIRECTION: begin
				req_run = din_s[DIN_ONE]; // see R3
				req_rev = din_s[DIN_TWO]; // see R3
			end
			SRC_PULSE_START_STOP, SRC_PULSE_START_STOP_WITH_DIRECTION: begin
				// open stop contact beats any start
				if (!din_s[DIN_TWO]) begin // see R4, R20
					latch = 1'b0;
				end else if (din_s[DIN_ONE]) begin // see R4, R20
					latch = 1'b1;
				end
				req_run = latch;
				if (src_now == SRC_PULSE_START_STOP_WITH_DIRECTION) begin
					req_rev = din_s[DIN_THREE]; // see R5
				end
			end
			SRC_PULSE_FORWARD_REVERSE_STOP: begin
				// both start buttons together: forward is taken
				if (!din_s[DIN_THREE]) begin // see R6, R20
					latch = 1'b0;
				end else if (din_s[DIN_ONE]) begin // see R6
					latch     = 1'b1;
					latch_rev = 1'b0;
				end else if (din_s[DIN_TWO]) begin // see R6
					latch     = 1'b1;
					latch_rev = 1'b1;
				end
				req_run = latch;
				req_rev = latch_rev;
			end
			SRC_TWO_WIRE_SIX: begin
				req_run = din_s[DIN_SIX]; // see R7
			end
			SRC_TWO_WIRE_SIX_WITH_DIRECTION: begin
				req_run = din_s[DIN_SIX]; // see R8
				req_rev = din_s[DIN_FIVE]; // see R8
			end
			SRC_KEYPAD: begin
				if (keypad_stop_i) begin // see R9
					latch = 1'b0;
				end else if (keypad_start_i) begin // see R9
					latch = 1'b1;
				end
				req_run = latch;
				req_rev = keypad_reverse_i; // see R9
			end
			SRC_COMMUNICATION_MODULE: begin
				req_run = comm_run_i; // see R10
				req_rev = comm_reverse_i; // see R10
			end
			default: begin
				req_run = 1'b0;
			end
		endcase

		// level schemes follow the input again as soon as the fault clears
		if (fault_now) begin // see R14
			req_run = 1'b0;
			latch   = 1'b0;
		end
		nxt_st.latch     = latch;
		nxt_st.latch_rev = latch_rev;
		nxt_st.loc_two   = loc_two_now;
		nxt_st.run       = req_run;

		unique case (st_ff.cfg.dir_lock)
			LOCK_FORWARD: nxt_st.reverse = 1'b0; // see R11
			LOCK_REVERSE: nxt_st.reverse = 1'b1; // see R11
			LOCK_REQUEST: nxt_st.reverse = req_rev; // see R11
			default:      nxt_st.reverse = 1'b0;
		endcase

		// user set switch by input level: low picks set one, high set two
		sel_level = (uset_input_idx_i < DIN_IDX_W'(DIN_COUNT)) ?
			din_s[uset_input_idx_i] : 1'b0; // see R18, R19
		din_edge          = uset_input_en_i && (sel_level != st_ff.uset_level); // see R18
		nxt_st.uset_level = sel_level;
		load_want         = uset_load_i || din_edge;
		uset_load_req     = load_want && !running_i; // see R12
		uset_sel_req      = din_edge ? sel_level : uset_sel_i;
		if (load_want && running_i) begin
			nxt_st.cfg_reject = 1'b1;
		end

		if (uset_done) begin // see R15, R16, R17
			nxt_st.cfg           = uset_data.cfg;
			nxt_st.restore       = uset_data;
			nxt_st.restore_valid = 1'b1;
		end
		if (cfg_write_i) begin
			if (running_i) begin // see R12
				nxt_st.cfg_reject = 1'b1;
			end else begin
				nxt_st.cfg = cfg_wdata_i;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			st_ff <= TOP_RESET;
		end else if (enable_i) begin
			st_ff <= nxt_st;
		end
	end

	assign run_o           = st_ff.run;
	assign reverse_o       = st_ff.reverse;
	assign loc_two_o       = st_ff.loc_two;
	assign faulted_o       = st_ff.faulted;
	assign cfg_o           = st_ff.cfg;
	assign cfg_reject_o    = st_ff.cfg_reject;
	assign uset_busy_o     = st_ff.uset_busy;
	assign restore_valid_o = st_ff.restore_valid;
	assign restore_o       = st_ff.restore;

	src_none_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R1
		(enable_i && src_now == SRC_NONE) |=> !run_o)
		else $error("run requested with no command source");

	two_wire_run_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R2
		(enable_i && src_now == SRC_TWO_WIRE_ONE && !fault_now) |=> run_o == $past(din_s[0]))
		else $error("two-wire run does not follow input one");

	dir_input_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R3
		(enable_i && src_now == SRC_TWO_WIRE_WITH_DIRECTION
			&& st_ff.cfg.dir_lock == LOCK_REQUEST) |=> reverse_o == $past(din_s[1]))
		else $error("direction does not follow input two");

	pulse_stop_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R4
		(enable_i && src_now == SRC_PULSE_START_STOP && !din_s[1]) |=> !run_o)
		else $error("open stop contact did not stop the drive");

	pulse_hold_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R20
		(enable_i && src_now == SRC_PULSE_START_STOP && din_s[1] && din_s[0] && !fault_now)
		##1 (enable_i && $stable(src_now) && din_s[1] && !fault_now) |=> run_o [*1])
		else $error("start pulse was not held");

	frs_reverse_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R6
		(enable_i && src_now == SRC_PULSE_FORWARD_REVERSE_STOP
			&& st_ff.cfg.dir_lock == LOCK_REQUEST && din_s[2] && !din_s[0] && din_s[1]
			&& !fault_now) |=> run_o && reverse_o)
		else $error("reverse start button did not start in reverse");

	six_run_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R7
		(enable_i && src_now == SRC_TWO_WIRE_SIX && !fault_now) |=> run_o == $past(din_s[5]))
		else $error("two-wire run does not follow input six");

	lock_fwd_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R11
		(enable_i && st_ff.cfg.dir_lock == LOCK_FORWARD) |=> !reverse_o)
		else $error("reverse shown under forward lock");

	cfg_reject_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R12
		(enable_i && cfg_write_i && running_i && !uset_done)
		|=> cfg_reject_o && cfg_o == $past(st_ff.cfg))
		else $error("setting changed while running");

	fault_resume_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R14
		(enable_i && st_ff.faulted && fault_reset_i && !fault_trip_i
			&& src_now == SRC_TWO_WIRE_SIX && din_s[5]) |=> run_o && !faulted_o)
		else $error("no immediate restart after fault reset");

endmodule : sst_start_stop_select

`default_nettype wire

// ### core/sst_pkg.sv
// shared types, widths, reset values and timing for the start/stop/direction selector
`default_nettype none

package sst_pkg;

	localparam int DIN_COUNT       = 6;
	localparam int DIN_IDX_W       = 3;
	localparam int DIN_ONE         = 0;
	localparam int DIN_TWO         = 1;
	localparam int DIN_THREE       = 2;
	localparam int DIN_FIVE        = 4;
	localparam int DIN_SIX         = 5;
	localparam int PANEL_REF_W     = 16;
	localparam int MOTOR_SETUP_W   = 16;
	localparam int MOTOR_ID_W      = 32;
	localparam int USER_SET_COUNT  = 2;
	localparam int SAVE_COUNT_W    = 32;

	// non-volatile store of a user set takes one minute
	localparam longint unsigned CLOCK_HZ     = 64'd50000000;
	localparam longint unsigned SAVE_TIME_MS = 64'd60000;
	localparam longint unsigned SAVE_CYCLES  = (SAVE_TIME_MS * CLOCK_HZ) / 64'd1000;

	typedef enum logic [3:0] {
		SRC_NONE,
		SRC_TWO_WIRE_ONE,
		SRC_TWO_WIRE_WITH_DIRECTION,
		SRC_PULSE_START_STOP,
		SRC_PULSE_START_STOP_WITH_DIRECTION,
		SRC_PULSE_FORWARD_REVERSE_STOP,
		SRC_TWO_WIRE_SIX,
		SRC_TWO_WIRE_SIX_WITH_DIRECTION,
		SRC_KEYPAD,
		SRC_COMMUNICATION_MODULE
	} sst_src_e;

	typedef enum logic [1:0] {
		LOCK_FORWARD,
		LOCK_REVERSE,
		LOCK_REQUEST
	} sst_lock_e;

	typedef enum logic [1:0] {
		LOC_ONE,
		LOC_TWO,
		LOC_INPUT,
		LOC_COMM
	} sst_locsel_e;

	typedef struct packed {
		sst_src_e               src_one;
		sst_src_e               src_two;
		sst_lock_e              dir_lock;
		sst_locsel_e            loc_sel;
		logic [DIN_IDX_W-1:0]   loc_input_idx;
	} sst_cfg_s;

	typedef struct packed {
		sst_cfg_s                  cfg;
		logic [PANEL_REF_W-1:0]    panel_ref;
		logic                      remote;
		logic [MOTOR_SETUP_W-1:0]  motor_setup;
		logic [MOTOR_ID_W-1:0]     motor_id;
	} sst_uset_s;

	localparam sst_cfg_s CFG_RESET = '{
		src_one:       SRC_NONE,
		src_two:       SRC_NONE,
		dir_lock:      LOCK_FORWARD,
		loc_sel:       LOC_ONE,
		loc_input_idx: 3'h0
	};

endpackage : sst_pkg

`default_nettype wire

// ### core/sst_sync.sv
// two-flop synchroniser for the digital input pins
`default_nettype none

module sst_sync
	import sst_pkg::*;
#(
	parameter int WIDTH = DIN_COUNT
) (
	input  wire logic             clock_i,
	input  wire logic             resetn_i,
	input  wire logic             enable_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sst_sync_state_s;

	sst_sync_state_s st_ff;
	sst_sync_state_s nxt_st;

	if (WIDTH < 1) begin : g_bad_width
		$error("sst_sync: WIDTH must be at least 1");
	end

	// meta is read by stable only
	always_comb begin
		nxt_st.meta   = async_i;
		nxt_st.stable = st_ff.meta;
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			st_ff <= '0;
		end else if (enable_i) begin
			st_ff <= nxt_st;
		end
	end

	assign sync_o = st_ff.stable;

endmodule : sst_sync

`default_nettype wire

// ### core/sst_user_set.sv
// two user parameter sets: timed save into the store, one-cycle recall
`default_nettype none

module sst_user_set
	import sst_pkg::*;
#(
	parameter longint unsigned SAVE_CYCLES_P = SAVE_CYCLES
) (
	input  wire logic      clock_i,
	input  wire logic      resetn_i,
	input  wire logic      enable_i,
	input  wire logic      save_i,
	input  wire logic      load_i,
	input  wire logic      sel_i,
	input  wire sst_uset_s snap_i,
	output logic           busy_o,
	output logic           done_o,
	output sst_uset_s      data_o
);

	typedef enum logic {
		US_IDLE,
		US_SAVING
	} sst_us_phase_e;

	typedef struct packed {
		sst_us_phase_e                   phase;
		logic                            sel;
		logic [SAVE_COUNT_W-1:0]         count;
		sst_uset_s                       pending;
		logic                            done;
		sst_uset_s                       data;
		sst_uset_s [USER_SET_COUNT-1:0]  store;
	} sst_us_state_s;

	localparam logic [SAVE_COUNT_W-1:0] SAVE_LOAD = SAVE_COUNT_W'(SAVE_CYCLES_P);

	sst_us_state_s st_ff;
	sst_us_state_s nxt_st;

	if (SAVE_CYCLES_P < 1 || SAVE_CYCLES_P > 64'hFFFFFFFF) begin : g_bad_save
		$error("sst_user_set: SAVE_CYCLES_P out of counter range");
	end

	always_comb begin
		nxt_st      = st_ff;
		nxt_st.done = 1'b0;
		unique case (st_ff.phase)
			US_IDLE: begin
				// save wins over a load in the same cycle
				if (save_i) begin // see R15, R16
					nxt_st.phase   = US_SAVING;
					nxt_st.sel     = sel_i;
					nxt_st.pending = snap_i;
					nxt_st.count   = SAVE_LOAD;
				end else if (load_i) begin // see R15, R16, R17
					nxt_st.data = st_ff.store[sel_i];
					nxt_st.done = 1'b1;
				end
			end
			US_SAVING: begin
				// requests while storing are dropped, the store is single ported
				if (st_ff.count <= SAVE_COUNT_W'(1)) begin
					nxt_st.store[st_ff.sel] = st_ff.pending;
					nxt_st.phase            = US_IDLE;
				end else begin
					nxt_st.count = st_ff.count - SAVE_COUNT_W'(1);
				end
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			st_ff <= '0;
		end else if (enable_i) begin
			st_ff <= nxt_st;
		end
	end

	assign busy_o = (st_ff.phase == US_SAVING);
	assign done_o = st_ff.done;
	assign data_o = st_ff.data;

	save_busy_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R15
		(enable_i && st_ff.phase == US_IDLE && save_i) |=> busy_o && !done_o)
		else $error("save request did not start storing");

	load_data_a: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R17
		(enable_i && st_ff.phase == US_IDLE && load_i && !save_i)
		|=> done_o && data_o == $past(st_ff.store[sel_i]))
		else $error("load did not return the selected set");

endmodule : sst_user_set

`default_nettype wire

// ### core/sst_placeholder_unused.sv
// intentionally empty design unit list
`default_nettype none
`default_nettype wire

// ### tb/sst_switches.sv
// switch and push-button panel wired to the digital input pins
`default_nettype none

module sst_switches
	import sst_pkg::*;
(
	input  wire logic                 clock_i,
	output logic      [DIN_COUNT-1:0] din_o
);
	timeunit 1ns;
	timeprecision 100ps;

	initial din_o = '0;

	// maintained switch, changes just after an edge
	task automatic set_pin(input int idx, input logic lvl);
		@(posedge clock_i);
		#1 din_o[idx] = lvl;
	endtask : set_pin

	// momentary press flips the rest level, so a closed stop contact opens;
	// held three cycles so the input synchroniser cannot miss it
	task automatic press(input int idx);
		logic rest;
		@(posedge clock_i);
		rest = din_o[idx];
		#1 din_o[idx] = ~rest;
		repeat (3) @(posedge clock_i);
		#1 din_o[idx] = rest;
	endtask : press

endmodule : sst_switches

`default_nettype wire

// ### tb/sst_start_stop_select_bench.sv
// self-checking bench for the start/stop/direction selector
`default_nettype none

module sst_start_stop_select_bench
	import sst_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed {
		logic [19:0] val;
		logic [19:0] care;
	} sst_note_s;

	localparam sst_src_e LVL_SRC [2] = '{SRC_TWO_WIRE_WITH_DIRECTION, SRC_TWO_WIRE_SIX_WITH_DIRECTION};
	localparam int       LVL_RUN [2] = '{DIN_ONE, DIN_SIX};
	localparam int       LVL_DIR [2] = '{DIN_TWO, DIN_FIVE};

	logic                     clock_i = 1'b0;
	logic                     resetn_i, enable_i, running_i, fault_trip_i, fault_reset_i;
	logic                     keypad_start_i, keypad_stop_i, keypad_reverse_i, chk;
	logic                     comm_run_i, comm_reverse_i, comm_loc_two_i, cfg_write_i;
	logic                     uset_save_i, uset_load_i, uset_sel_i, uset_input_en_i, remote_i;
	logic [DIN_IDX_W-1:0]     uset_input_idx_i;
	logic [PANEL_REF_W-1:0]   panel_ref_i;
	logic [MOTOR_SETUP_W-1:0] motor_setup_i;
	logic [MOTOR_ID_W-1:0]    motor_id_i;
	logic                     run_o, reverse_o, loc_two_o, faulted_o;
	logic                     cfg_reject_o, uset_busy_o, restore_valid_o;
	sst_cfg_s                 cfg_wdata_i, cfg_o, cur;
	sst_uset_s                restore_o, snap;
	wire logic [DIN_COUNT-1:0] din;
	logic [31:0]              seed;
	int                       n_errors = 0;
	int                       tests_run = 0;
	int                       k, j;
	sst_note_s                note_q [$];
	sst_uset_s                rest_q [$];

	sst_switches i_sst_switches (.clock_i, .din_o(din));

	// short save time keeps the store timer inside the run
	sst_start_stop_select #(.SAVE_CYCLES_P(64'd8)) i_sst_start_stop_select (
		.clock_i, .resetn_i, .enable_i, .din_i(din), .running_i, .fault_trip_i,
		.fault_reset_i, .keypad_start_i, .keypad_stop_i, .keypad_reverse_i, .comm_run_i,
		.comm_reverse_i, .comm_loc_two_i, .cfg_write_i, .cfg_wdata_i, .uset_save_i,
		.uset_load_i, .uset_sel_i, .uset_input_en_i, .uset_input_idx_i, .panel_ref_i,
		.remote_i, .motor_setup_i, .motor_id_i, .run_o, .reverse_o, .loc_two_o, .faulted_o,
		.cfg_o, .cfg_reject_o, .uset_busy_o, .restore_valid_o, .restore_o
	);

	always #10 clock_i = ~clock_i;

	// oldest note is compared on a check strobe, oldest expected restore on a restore pulse
	always @(posedge clock_i) begin : watch
		sst_note_s   n;
		sst_uset_s   e;
		logic [19:0] obs;
		obs = {run_o, reverse_o, loc_two_o, faulted_o, cfg_reject_o, cfg_o};
		if (chk === 1'b1) begin
			n = note_q.pop_front();
			tests_run++;
			if (((obs ^ n.val) & n.care) !== 20'h00000) begin
				n_errors++;
				$display("BAD status exp %h got %h", n.val, obs);
			end
		end
		if (restore_valid_o === 1'b1) begin
			e = '0;
			if (rest_q.size() != 0) e = rest_q.pop_front();
			tests_run++;
			if (restore_o !== e || cfg_o !== e.cfg) begin
				n_errors++;
				$display("BAD restore exp %h got %h", e, restore_o);
			end
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic tick(input int n = 1);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : tick

	task automatic pulse(ref logic sig);
		tick();
		sig = 1'b1;
		tick();
		sig = 1'b0;
	endtask : pulse

	task automatic raise(input logic [3:0] st, input logic rej, input logic [19:0] care);
		note_q.push_back('{val: {st, rej, cur}, care: care});
		chk = 1'b1;
		tick();
		chk = 1'b0;
	endtask : raise

	// status is {run, reverse, location two, faulted}; pin to output takes three edges
	task automatic check(input logic [3:0] st);
		tick(4);
		raise(st, 1'b0, 20'hFFFFF);
	endtask : check

	task automatic put_cfg(input sst_src_e s1, s2, input sst_lock_e lk, input sst_locsel_e ls);
		tick();
		cfg_write_i = 1'b1;
		cfg_wdata_i = '{s1, s2, lk, ls, 3'h4};
		tick();
		cfg_write_i = 1'b0;
		if (running_i === 1'b0) cur = cfg_wdata_i;
		raise(4'h0, running_i, 20'h0FFFF);
	endtask : put_cfg

	task automatic load_one();
		uset_sel_i = 1'b0;
		if (running_i === 1'b0) rest_q.push_back(snap);
		pulse(uset_load_i);
		if (running_i === 1'b1) begin
			raise(4'h0, 1'b1, 20'h0FFFF);
		end else begin
			tick(3);
			cur = snap.cfg;
		end
	endtask : load_one

	task automatic print_verdict();
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict

	initial begin
		{resetn_i, running_i, fault_trip_i, fault_reset_i, keypad_start_i, keypad_stop_i} = '0;
		{keypad_reverse_i, comm_run_i, comm_reverse_i, comm_loc_two_i, cfg_write_i} = '0;
		{uset_save_i, uset_load_i, uset_sel_i, uset_input_en_i, remote_i, chk} = '0;
		{uset_input_idx_i, panel_ref_i, motor_setup_i, motor_id_i} = '0;
		enable_i = 1'b1;
		cfg_wdata_i = CFG_RESET;
		cur = CFG_RESET;
		seed = 32'd91;
		tick(2);
		resetn_i = 1'b1;
		check(4'h0);
		// nothing may start the motor while the source is none
		i_sst_switches.set_pin(DIN_ONE, 1'b1);
		i_sst_switches.set_pin(DIN_SIX, 1'b1);
		comm_run_i = 1'b1;
		pulse(keypad_start_i);
		check(4'h0);
		put_cfg(SRC_TWO_WIRE_ONE, SRC_NONE, LOCK_REVERSE, LOC_ONE);
		check(4'hC);
		i_sst_switches.set_pin(DIN_ONE, 1'b0);
		check(4'h4);
		for (k = 0; k < 2; k++) begin
			put_cfg(LVL_SRC[k], SRC_NONE, LOCK_REQUEST, LOC_ONE);
			i_sst_switches.set_pin(LVL_RUN[k], 1'b1);
			i_sst_switches.set_pin(LVL_DIR[k], 1'b1);
			check(4'hC);
			i_sst_switches.set_pin(LVL_DIR[k], 1'b0);
			check(4'h8);
			put_cfg(LVL_SRC[k], SRC_NONE, LOCK_REVERSE, LOC_ONE);
			check(4'hC);
			i_sst_switches.set_pin(LVL_RUN[k], 1'b0);
			check(4'h4);
		end
		put_cfg(SRC_TWO_WIRE_SIX, SRC_NONE, LOCK_FORWARD, LOC_ONE);
		i_sst_switches.set_pin(DIN_SIX, 1'b1);
		check(4'h8);
		pulse(fault_trip_i);
		check(4'h1);
		pulse(fault_reset_i);
		check(4'h8);
		// enable low freezes the synchroniser and the decode alike
		enable_i = 1'b0;
		i_sst_switches.set_pin(DIN_SIX, 1'b0);
		check(4'h8);
		enable_i = 1'b1;
		check(4'h0);
		put_cfg(SRC_PULSE_START_STOP, SRC_NONE, LOCK_REVERSE, LOC_ONE);
		i_sst_switches.set_pin(DIN_TWO, 1'b1);
		i_sst_switches.press(DIN_ONE);
		check(4'hC);
		i_sst_switches.press(DIN_TWO);
		check(4'h4);
		i_sst_switches.set_pin(DIN_TWO, 1'b0);
		i_sst_switches.set_pin(DIN_ONE, 1'b1);
		check(4'h4);
		i_sst_switches.set_pin(DIN_ONE, 1'b0);
		put_cfg(SRC_PULSE_START_STOP_WITH_DIRECTION, SRC_NONE, LOCK_REQUEST, LOC_ONE);
		i_sst_switches.set_pin(DIN_TWO, 1'b1);
		i_sst_switches.set_pin(DIN_THREE, 1'b1);
		i_sst_switches.press(DIN_ONE);
		check(4'hC);
		i_sst_switches.set_pin(DIN_THREE, 1'b0);
		check(4'h8);
		i_sst_switches.press(DIN_TWO);
		check(4'h0);
		put_cfg(SRC_PULSE_FORWARD_REVERSE_STOP, SRC_NONE, LOCK_REQUEST, LOC_ONE);
		i_sst_switches.set_pin(DIN_TWO, 1'b0);
		i_sst_switches.set_pin(DIN_THREE, 1'b1);
		i_sst_switches.press(DIN_TWO);
		check(4'hC);
		i_sst_switches.press(DIN_THREE);
		check(4'h4);
		i_sst_switches.press(DIN_ONE);
		check(4'h8);
		i_sst_switches.press(DIN_THREE);
		check(4'h0);
		put_cfg(SRC_KEYPAD, SRC_NONE, LOCK_REQUEST, LOC_ONE);
		keypad_reverse_i = 1'b1;
		pulse(keypad_start_i);
		check(4'hC);
		pulse(keypad_stop_i);
		check(4'h4);
		put_cfg(SRC_COMMUNICATION_MODULE, SRC_NONE, LOCK_REQUEST, LOC_ONE);
		comm_reverse_i = 1'b1;
		check(4'hC);
		comm_reverse_i = 1'b0;
		check(4'h8);
		put_cfg(SRC_NONE, SRC_COMMUNICATION_MODULE, LOCK_REQUEST, LOC_TWO);
		check(4'hA);
		put_cfg(SRC_NONE, SRC_COMMUNICATION_MODULE, LOCK_REQUEST, LOC_COMM);
		check(4'h0);
		comm_loc_two_i = 1'b1;
		check(4'hA);
		// snapshot of live values, then a timed save into set one
		{panel_ref_i, motor_setup_i} = rnd();
		motor_id_i = rnd();
		remote_i = 1'b1;
		snap = '{cur, panel_ref_i, remote_i, motor_setup_i, motor_id_i};
		uset_sel_i = 1'b0;
		pulse(uset_save_i);
		j = 0;
		for (k = 0; k < 8 && uset_busy_o !== 1'b1; k++) tick();
		while (uset_busy_o === 1'b1 && j < 40) begin
			tick();
			j++;
		end
		tests_run++;
		if (j != 8) begin
			n_errors++;
			$display("BAD save busy cycles exp 8 got %0d", j);
			if (j >= 40) print_verdict();
		end
		{panel_ref_i, motor_setup_i} = rnd();
		motor_id_i = rnd();
		remote_i = 1'b0;
		put_cfg(SRC_TWO_WIRE_ONE, SRC_NONE, LOCK_FORWARD, LOC_ONE);
		check(4'h0);
		// loads and writes are refused while the motor turns
		running_i = 1'b1;
		load_one();
		put_cfg(SRC_KEYPAD, SRC_NONE, LOCK_REVERSE, LOC_TWO);
		running_i = 1'b0;
		load_one();
		check(4'hA);
		// input five switches sets: high loads the never-saved set two
		uset_input_idx_i = 3'h4;
		uset_input_en_i = 1'b1;
		tick(4);
		rest_q.push_back('0);
		i_sst_switches.set_pin(DIN_FIVE, 1'b1);
		tick(4);
		cur = '0;
		check(4'h0);
		rest_q.push_back(snap);
		i_sst_switches.set_pin(DIN_FIVE, 1'b0);
		tick(4);
		cur = snap.cfg;
		check(4'hA);
		// location picked by input five, which no longer switches sets
		uset_input_en_i = 1'b0;
		put_cfg(SRC_NONE, SRC_COMMUNICATION_MODULE, LOCK_REQUEST, LOC_INPUT);
		check(4'h0);
		i_sst_switches.set_pin(DIN_FIVE, 1'b1);
		check(4'hA);
		tick(4);
		tests_run++;
		if (rest_q.size() != 0) begin
			n_errors++;
			$display("BAD restore count exp 0 got %0d", rest_q.size());
		end
		print_verdict();
	end

endmodule : sst_start_stop_select_bench

`default_nettype wire
